// file: dpio_pkg.sv
/*
 * Package for the digital port I/O block: register offsets, field layout,
 * reset values and the carrier structs shared by the port modules.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
package dpio_pkg;

	localparam int DPIO_PINS  = 8;
	localparam int DPIO_AW    = 8;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [DPIO_AW-1:0] DPIO_OFS_LEVEL = 8'h00;
	localparam logic [DPIO_AW-1:0] DPIO_OFS_LATCH = 8'h04;
	localparam logic [DPIO_AW-1:0] DPIO_OFS_DIR   = 8'h08;
	localparam logic [DPIO_AW-1:0] DPIO_OFS_ANSEL = 8'h0C;
	localparam logic [DPIO_AW-1:0] DPIO_OFS_WPU   = 8'h10;
	localparam logic [DPIO_AW-1:0] DPIO_OFS_INLVL = 8'h14;
	localparam logic [DPIO_AW-1:0] DPIO_OFS_SLEW  = 8'h18;
	localparam logic [DPIO_AW-1:0] DPIO_OFS_ODRN  = 8'h1C;
	localparam logic [DPIO_AW-1:0] DPIO_OFS_PERI  = 8'h20;

	// ****************************************
	// Implemented bits and reset values
	// ****************************************
	localparam logic [7:0] DPIO_IMPL_MASK = 8'h37;
	localparam logic [7:0] DPIO_RST_LATCH = 8'h00;
	localparam logic [7:0] DPIO_RST_DIR   = 8'h37;
	localparam logic [7:0] DPIO_RST_ANSEL = 8'h37;
	localparam logic [7:0] DPIO_RST_WPU   = 8'h00;
	localparam logic [7:0] DPIO_RST_INLVL = 8'h00;
	localparam logic [7:0] DPIO_RST_SLEW  = 8'h37;
	localparam logic [7:0] DPIO_RST_ODRN  = 8'h00;
	localparam logic [7:0] DPIO_RST_PERI  = 8'h00;

	// Per-pin pad controls toward the pad ring
	typedef struct packed {
		logic [7:0] out_level;
		logic [7:0] out_en;
		logic [7:0] in_buf_en;
		logic [7:0] pullup_en;
		logic [7:0] thresh_st;
		logic [7:0] slew_lim;
	} dpio_pad_ctl_s;

	// Peripheral requests from the routing logic
	typedef struct packed {
		logic [7:0] dig_out_en;
		logic [7:0] dig_out_val;
		logic [7:0] ana_out_en;
	} dpio_peri_req_s;

endpackage

// file: dpio_sync.sv
/*
 * Two-flop synchroniser bank for the raw pin levels.
 * Assumes pin inputs are asynchronous to ref_clk.
 */
`timescale 1ns/10ps
module dpio_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             ref_clk, // System clock
	input  wire logic             rst,     // Async reset, active high
	input  wire logic [WIDTH-1:0] d_async, // Raw levels
	output logic      [WIDTH-1:0] q_sync   // Synchronised levels
);
	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
		end else begin
			stage1_reg <= d_async;
			stage2_reg <= stage1_reg;
		end
	end

	assign q_sync = stage2_reg;
endmodule

// file: dpio_pin_mux.sv
/*
 * Per-pin output ownership: latch, routed digital peripheral, analog output.
 * Assumes peripheral requests already come through the routing select.
 */
`timescale 1ns/10ps
module dpio_pin_mux
	import dpio_pkg::*;
#(
	parameter int PINS = 8
) (
	input  wire logic [PINS-1:0] latch,       // Output latch
	input  wire logic [PINS-1:0] dir_in,      // 1 = input (driver off)
	input  wire logic [PINS-1:0] odrain,      // Open-drain enable
	input  wire logic [PINS-1:0] impl,        // Implemented pins
	input  wire logic [PINS-1:0] peri_en,     // Routed peripheral owns pin
	input  wire logic [PINS-1:0] peri_val,    // Routed peripheral level
	input  wire logic [PINS-1:0] ana_out,     // Analog output enabled
	output logic      [PINS-1:0] drv_level,   // Pad output level
	output logic      [PINS-1:0] drv_en       // Pad output enable
);
	genvar g;
	generate
		for (g = 0; g < PINS; g++) begin : g_pin
			logic src;
			// Latch owns the pin unless routing hands it to a peripheral
			assign src = peri_en[g] ? peri_val[g] : latch[g];
			assign drv_level[g] = src;
			// Analog output overrides all digital drive; ansel alone does not
			assign drv_en[g] = impl[g] & ~ana_out[g] & ~dir_in[g]
				& ~(odrain[g] & src);
		end
	endgenerate
endmodule

// file: dpio_port.sv
/*
 * Digital port I/O: APB register file and per-pin control for one port.
 * Holds latch, direction, analog select, pull-up, threshold, slew and
 * open-drain controls plus a routing enable per pin.
 * Assumes pins arrive asynchronously and peripherals are routed upstream.
 */
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/10ps

// Function
// - After reset, latch owns every pin output
// - Other functions reach pins only via routing
// - Pin-level register write updates the latch
// - Latch read returns stored latch values
// - Pin-level read returns sampled pin levels
// - Analog select disables digital input buffer
// - Peripheral-owned pin not latch-driven, still readable
// - Analog inputs active only in analog mode
// - Digital outputs may drive analog-mode pins
// - Analog output forces driver high impedance
// - Latch holds pins 5,4,2,1,0
// - Latch bits 7,6,3 read zero
// - Full per-pin control register set provided
// - Analog select 1 analog, 0 digital
module dpio_port
	import dpio_pkg::*;
#(
	parameter int          PINS = DPIO_PINS,
	parameter logic [7:0]  IMPL = DPIO_IMPL_MASK
) (
	input  wire logic                 ref_clk,     // 20 MHz system clock
	input  wire logic                 rst,         // Async reset, active high
	input  wire logic                 psel,        // APB select
	input  wire logic                 penable,     // APB enable
	input  wire logic                 pwrite,      // APB direction
	input  wire logic [DPIO_AW-1:0]   paddr,       // APB byte address
	input  wire logic [31:0]          pwdata,      // APB write data
	input  wire logic [3:0]           pstrb,       // APB byte strobes
	output logic                      pready,      // APB ready
	output logic      [31:0]          prdata,      // APB read data
	output logic                      pslverr,     // APB error
	input  wire logic [PINS-1:0]      pin_in,      // Raw pad levels
	input  wire dpio_peri_req_s       peri_req,    // Routed peripheral requests
	output dpio_pad_ctl_s             pad_ctl,     // Pad controls
	output logic      [PINS-1:0]      pad_odrain,  // Open-drain select
	output logic      [PINS-1:0]      ana_in_en,   // Analog input connect
	output logic      [PINS-1:0]      dig_in_level // Digital input to peripherals
);
	import dpio_pkg::*;

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] latch_reg;
	logic [7:0] dir_reg;
	logic [7:0] ansel_reg;
	logic [7:0] wpu_reg;
	logic [7:0] inlvl_reg;
	logic [7:0] slew_reg;
	logic [7:0] odrn_reg;
	logic [7:0] peri_reg;
	logic [31:0] rdata_reg;
	logic        err_reg;
	logic [PINS-1:0] pin_sync;
	logic [PINS-1:0] drv_level;
	logic [PINS-1:0] drv_en;
	logic [PINS-1:0] peri_own;

	logic wr_en;
	logic rd_en;
	logic [7:0] wbyte;

	function automatic logic addr_known(input logic [DPIO_AW-1:0] a);
		unique case (a)
			DPIO_OFS_LEVEL, DPIO_OFS_LATCH, DPIO_OFS_DIR, DPIO_OFS_ANSEL,
			DPIO_OFS_WPU, DPIO_OFS_INLVL, DPIO_OFS_SLEW, DPIO_OFS_ODRN,
			DPIO_OFS_PERI: addr_known = 1'b1;
			default:       addr_known = 1'b0;
		endcase
	endfunction

	function automatic logic hit(input logic [DPIO_AW-1:0] a, input logic [DPIO_AW-1:0] o);
		hit = (a == o);
	endfunction

	// Single-cycle access phase: setup then access, pready always high
	assign wr_en  = psel & penable & pwrite & pstrb[0] & addr_known(paddr);
	assign rd_en  = psel & ~penable & ~pwrite;
	assign wbyte  = pwdata[7:0] & IMPL;
	assign pready = 1'b1;
	assign prdata = rdata_reg;
	assign pslverr = psel & penable & err_reg;

	// ****************************************
	// Pin-level sampling
	// ****************************************
	dpio_sync #(
		.WIDTH(PINS)
	) u_sync (
		.ref_clk(ref_clk),
		.rst    (rst),
		.d_async(pin_in),
		.q_sync (pin_sync)
	);

	// ****************************************
	// Output latch
	// ****************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			latch_reg <= DPIO_RST_LATCH;
		end else if (wr_en && (hit(paddr, DPIO_OFS_LATCH) || hit(paddr, DPIO_OFS_LEVEL))) begin
			latch_reg <= wbyte;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dir_reg   <= DPIO_RST_DIR;
			ansel_reg <= DPIO_RST_ANSEL;
			wpu_reg   <= DPIO_RST_WPU;
			inlvl_reg <= DPIO_RST_INLVL;
			slew_reg  <= DPIO_RST_SLEW;
			odrn_reg  <= DPIO_RST_ODRN;
		end else if (wr_en) begin
			if (hit(paddr, DPIO_OFS_DIR)) begin
				dir_reg <= wbyte;
			end
			if (hit(paddr, DPIO_OFS_ANSEL)) begin
				ansel_reg <= wbyte;
			end
			if (hit(paddr, DPIO_OFS_WPU)) begin
				wpu_reg <= wbyte;
			end
			if (hit(paddr, DPIO_OFS_INLVL)) begin
				inlvl_reg <= wbyte;
			end
			if (hit(paddr, DPIO_OFS_SLEW)) begin
				slew_reg <= wbyte;
			end
			if (hit(paddr, DPIO_OFS_ODRN)) begin
				odrn_reg <= wbyte;
			end
		end
	end

	// Routing enables cleared by reset so the latch owns every pin
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			peri_reg <= DPIO_RST_PERI;
		end else if (wr_en && hit(paddr, DPIO_OFS_PERI)) begin
			peri_reg <= wbyte;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata_reg <= 32'h0000_0000;
			err_reg   <= 1'b0;
		end else if (psel && !penable) begin
			err_reg   <= ~addr_known(paddr);
			rdata_reg <= 32'h0000_0000;
			if (rd_en) begin
				unique case (paddr)
					DPIO_OFS_LEVEL: rdata_reg[7:0] <= pin_sync & ~ansel_reg & IMPL;
					DPIO_OFS_LATCH: rdata_reg[7:0] <= latch_reg;
					DPIO_OFS_DIR:   rdata_reg[7:0] <= dir_reg;
					DPIO_OFS_ANSEL: rdata_reg[7:0] <= ansel_reg;
					DPIO_OFS_WPU:   rdata_reg[7:0] <= wpu_reg;
					DPIO_OFS_INLVL: rdata_reg[7:0] <= inlvl_reg;
					DPIO_OFS_SLEW:  rdata_reg[7:0] <= slew_reg;
					DPIO_OFS_ODRN:  rdata_reg[7:0] <= odrn_reg;
					DPIO_OFS_PERI:  rdata_reg[7:0] <= peri_reg;
					default:        rdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ****************************************
	// Pin ownership
	// ****************************************
	// A peripheral only owns a pin when routing enables it and it requests drive
	assign peri_own = peri_reg[PINS-1:0] & peri_req.dig_out_en;

	dpio_pin_mux #(
		.PINS(PINS)
	) u_mux (
		.latch    (latch_reg[PINS-1:0]),
		.dir_in   (dir_reg[PINS-1:0]),
		.odrain   (odrn_reg[PINS-1:0]),
		.impl     (IMPL[PINS-1:0]),
		.peri_en  (peri_own),
		.peri_val (peri_req.dig_out_val),
		.ana_out  (peri_req.ana_out_en),
		.drv_level(drv_level),
		.drv_en   (drv_en)
	);

	// ****************************************
	// Pad controls
	// ****************************************
	assign pad_ctl.out_level = drv_level;
	assign pad_ctl.out_en    = drv_en;
	assign pad_ctl.in_buf_en = ~ansel_reg & IMPL;
	assign pad_ctl.pullup_en = wpu_reg & ~drv_en & IMPL;
	assign pad_ctl.thresh_st = inlvl_reg;
	assign pad_ctl.slew_lim  = slew_reg;
	assign pad_odrain        = odrn_reg;
	assign ana_in_en         = ansel_reg & IMPL;
	// Peripheral inputs still see the pin while it is peripheral-owned
	assign dig_in_level      = pin_sync & ~ansel_reg & IMPL;

endmodule

// file: dpio_port_assertions.sv
/* Checker for dpio_port, watching its ports only.
   Assumes one clock domain and a master that keeps the APB handshake. */
`timescale 1ns/10ps
module dpio_port_chk (
	input wire logic                     ref_clk,     // Clock
	input wire logic                     rst,         // Reset
	input wire logic                     psel,        // APB select
	input wire logic                     penable,     // APB enable
	input wire logic                     pwrite,      // APB direction
	input wire logic [7:0]               paddr,       // APB address
	input wire logic [31:0]              pwdata,      // Write data
	input wire logic [3:0]               pstrb,       // Strobes
	input wire logic [31:0]              prdata,      // Read data
	input wire logic                     pslverr,     // Error
	input wire logic [7:0]               pin_in,      // Pad levels
	input wire dpio_pkg::dpio_peri_req_s peri_req,    // Peripherals
	input wire dpio_pkg::dpio_pad_ctl_s  pad_ctl,     // Pad controls
	input wire logic [7:0]               ana_in_en,   // Analog connect
	input wire logic [7:0]               dig_in_level // Digital input
);
	import dpio_pkg::*;
	// ****************************************
	// Latch mirror and properties
	// ****************************************
	logic [7:0] lat_m;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			lat_m <= 8'h00;
		else if (psel && penable && pwrite && pstrb[0] &&
			(paddr == DPIO_OFS_LATCH || paddr == DPIO_OFS_LEVEL))
			lat_m <= pwdata[7:0] & DPIO_IMPL_MASK;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	AST_RST_OWNER: assert property ($fell(rst) |-> pad_ctl.out_en == 8'h00)
		else $error("Pad driven right after reset");
	AST_ANA_HIZ: assert property ((pad_ctl.out_en & peri_req.ana_out_en) == 8'h00)
		else $error("Driver on while analog output enabled");
	AST_IN_BUF: assert property ((ana_in_en & pad_ctl.in_buf_en) == 8'h00)
		else $error("Input buffer on for analog pin");
	AST_ANA_IMPL: assert property ((ana_in_en & ~DPIO_IMPL_MASK) == 8'h00)
		else $error("Analog connect on missing pin");
	AST_PIN_SYNC: assert property (!$past(rst) && !$past(rst, 2) |->
		dig_in_level == ($past(pin_in, 2) & ~ana_in_en & DPIO_IMPL_MASK))
		else $error("Digital input level wrong");
	AST_LATCH_OUT: assert property (((pad_ctl.out_level ^ lat_m) &
		~peri_req.dig_out_en & DPIO_IMPL_MASK) == 8'h00)
		else $error("Pad level differs from latch");
	AST_LATCH_RD: assert property (psel && penable && !pwrite && paddr == DPIO_OFS_LATCH
		|-> prdata == {24'h000000, lat_m})
		else $error("Latch read wrong");
	AST_UPPER_ZERO: assert property (psel && penable && !pwrite
		|-> prdata[31:8] == 24'h000000)
		else $error("Upper read bits set");
	AST_SLVERR: assert property (psel && penable |->
		pslverr == (paddr > DPIO_OFS_PERI || paddr[1:0] != 2'h0))
		else $error("Error response wrong");
endmodule

bind dpio_port dpio_port_chk u_chk (.ref_clk(ref_clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pslverr(pslverr), .pin_in(pin_in), .peri_req(peri_req),
	.pad_ctl(pad_ctl), .ana_in_en(ana_in_en), .dig_in_level(dig_in_level));

// file: dpio_pads.sv
/* Pin model: resolves each pad from the block's driver and the outside.
   Assumes the bench drives ext on every pin. */
`timescale 1ns/10ps
module dpio_pads (
	input wire dpio_pkg::dpio_pad_ctl_s pad_ctl, // Pad controls
	input wire logic [7:0]              ext,     // Outside level
	output logic     [7:0]              pin_in   // Resolved level
);
	import dpio_pkg::*;
	// Block wins where its driver is on
	assign pin_in = (pad_ctl.out_en & pad_ctl.out_level) | (~pad_ctl.out_en & ext);
endmodule

// file: test_digital_port_io.sv
/* Bench for dpio_port: APB master tasks and directed scenarios.
   Assumes the package offsets and a 20 MHz clock. */
`timescale 1ns/10ps
module test_digital_port_io;
	import dpio_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic [7:0] ext = 8'h00;
	dpio_peri_req_s peri_req = '0;
	logic pready, pslverr, perr;
	logic [31:0] prdata, q;
	logic [7:0] pin_in, pad_odrain, ana_in_en, dig_in_level;
	dpio_pad_ctl_s pad_ctl;
	int n_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	initial forever #25 ref_clk = ~ref_clk;
	dpio_port dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .pin_in(pin_in), .peri_req(peri_req),
		.pad_ctl(pad_ctl), .pad_odrain(pad_odrain), .ana_in_en(ana_in_en),
		.dig_in_level(dig_in_level));
	dpio_pads pads (.pad_ctl(pad_ctl), .ext(ext), .pin_in(pin_in));
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic print_verdict();
		$display("Checks %0d, errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 8'h00);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		logic [7:0] rv [9];
		rv = '{8'h00, DPIO_RST_LATCH, DPIO_RST_DIR, DPIO_RST_ANSEL, DPIO_RST_WPU,
			DPIO_RST_INLVL, DPIO_RST_SLEW, DPIO_RST_ODRN, DPIO_RST_PERI};
		chk("out_en", 32'h0, {24'h0, pad_ctl.out_en});
		for (int i = 0; i < 9; i++) begin
			rd(8'(i * 4));
			chk("reset value", {24'h0, rv[i]}, q);
		end
	endtask
	task automatic t_latch();
		wr(DPIO_OFS_LATCH, 8'hFF);
		rd(DPIO_OFS_LATCH);
		chk("latch", 32'h37, q);
		wr(DPIO_OFS_LEVEL, 8'h05);
		rd(DPIO_OFS_LATCH);
		chk("latch", 32'h05, q);
		wr(DPIO_OFS_ANSEL, 8'h00);
		wr(DPIO_OFS_DIR, 8'h00);
		chk("out_en", 32'h37, {24'h0, pad_ctl.out_en});
		chk("out_level", 32'h05, {24'h0, pad_ctl.out_level & 8'h37});
		wr(DPIO_OFS_DIR, 8'h37);
		ext <= 8'h32;
		repeat (3) @(posedge ref_clk);
		rd(DPIO_OFS_LEVEL);
		chk("level", 32'h32, q);
		rd(DPIO_OFS_LATCH);
		chk("latch", 32'h05, q);
	endtask
	task automatic t_analog();
		ext <= 8'h3F;
		wr(DPIO_OFS_ANSEL, 8'h01);
		wr(DPIO_OFS_DIR, 8'h00);
		repeat (3) @(posedge ref_clk);
		rd(DPIO_OFS_LEVEL);
		chk("level", 32'h04, q);
		chk("dig_in_level", 32'h04, {24'h0, dig_in_level});
		chk("ana_in_en", 32'h01, {24'h0, ana_in_en});
		chk("out_en", 32'h37, {24'h0, pad_ctl.out_en});
		peri_req.ana_out_en <= 8'h01;
		repeat (2) @(posedge ref_clk);
		chk("out_en", 32'h36, {24'h0, pad_ctl.out_en});
		peri_req.ana_out_en <= 8'h00;
	endtask
	task automatic t_peri();
		wr(DPIO_OFS_ANSEL, 8'h00);
		peri_req.dig_out_en <= 8'h02;
		peri_req.dig_out_val <= 8'h02;
		repeat (2) @(posedge ref_clk);
		chk("out_level", 32'h05, {24'h0, pad_ctl.out_level & 8'h37});
		wr(DPIO_OFS_PERI, 8'h02);
		chk("out_level", 32'h07, {24'h0, pad_ctl.out_level & 8'h37});
		repeat (3) @(posedge ref_clk);
		rd(DPIO_OFS_LEVEL);
		chk("level", 32'h07, q);
		rd(8'h40);
		chk("unmapped", 32'h0, q);
		chk("pslverr", 32'h1, {31'h0, perr});
	endtask
	// Pad side controls, open drain, byte strobe and a reset in mid-run
	task automatic t_pads();
		wr(DPIO_OFS_WPU, 8'hFF);
		wr(DPIO_OFS_INLVL, 8'h21);
		wr(DPIO_OFS_SLEW, 8'h10);
		wr(DPIO_OFS_ODRN, 8'h05);
		chk("pad_odrain", 32'h05, {24'h0, pad_odrain});
		chk("out_en", 32'h32, {24'h0, pad_ctl.out_en});
		chk("pullup_en", 32'h05, {24'h0, pad_ctl.pullup_en});
		chk("thresh_st", 32'h21, {24'h0, pad_ctl.thresh_st});
		chk("slew_lim", 32'h10, {24'h0, pad_ctl.slew_lim});
		chk("in_buf_en", 32'h37, {24'h0, pad_ctl.in_buf_en});
		wr(DPIO_OFS_LATCH, 8'h00);
		chk("out_en", 32'h37, {24'h0, pad_ctl.out_en});
		pstrb <= 4'hE;
		wr(DPIO_OFS_LATCH, 8'h37);
		pstrb <= 4'hF;
		rd(DPIO_OFS_LATCH);
		chk("latch", 32'h00, q);
		wr(DPIO_OFS_LATCH, 8'h02);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		chk("out_en", 32'h00, {24'h0, pad_ctl.out_en});
		wr(DPIO_OFS_DIR, 8'h00);
		chk("out_level", 32'h00, {24'h0, pad_ctl.out_level & 8'h37});
		chk("out_en", 32'h37, {24'h0, pad_ctl.out_en});
		rd(DPIO_OFS_PERI);
		chk("routing", 32'h00, q);
	endtask
	// Cuts a hang short
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			print_verdict();
		end
	end
	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_latch();
		t_analog();
		t_peri();
		t_pads();
		print_verdict();
	end
endmodule
